// >>> logic/e1rst_core.sv
// module: chip-clear sequencing, default register bank and apb register port

// Behaviour
// - chip_clear_input low for at least 10 us enters the clear state
// - during clear every output stage is released (high impedance)
// - clear resets internal state and loads register defaults
// - after clear the device runs E1 doubleframe until reprogrammed
// - status registers are read-only and refreshed every cycle by hardware
// - byte and word accesses reach every control and status register
// - clock generator configuration registers default to zero (2.048 MHz)
// - first framer mode register defaults to zero: NRZ, no alarm simulation
// - second and third framer mode registers default to zero
// - system interface configuration registers default to zero
// - channel loop, service word, spare bits and transparent mode default cleared
// - clock offsets default zero, slot offsets default 9C, both meaning cleared
// - line interface and loss-of-signal count registers default to zero
// - three pulse-shape registers default 7B, 03, 40, transmitter tristated
// - every interrupt mask register defaults to all ones
// - receive and transmit slot selections default to zero
// - first clock mux register defaults to zero
// - second clock mux register defaults to zero
// - signaling controller mode register defaults to zero
module e1rst_core (
    input  wire logic                       core_clk,
    input  wire logic                       rst_n,
    input  wire logic                       chip_clear_input,
    input  wire logic [7:0]                 line_status,
    input  wire e1rst_pkg::e1rst_apb_req_s  apb_req,
    output e1rst_pkg::e1rst_apb_rsp_s       apb_rsp,
    output e1rst_pkg::e1rst_cfg_s           cfg,
    output e1rst_pkg::e1rst_regs_t          ctl_regs
);

    e1rst_pkg::e1rst_state_s   s_r;
    e1rst_pkg::e1rst_state_s   s_nxt;
    logic [e1rst_pkg::IDX_W-1:0] reg_idx;
    logic                      access;
    logic                      wr_commit;
    logic                      clearing;
    logic [e1rst_pkg::NCTL-1:0] wr_hit;

    // word index of the access; low address bits must be zero
    assign reg_idx = apb_req.paddr[e1rst_pkg::ADDR_W-1:2];
    assign access  = apb_req.psel && apb_req.penable;

    // lane zero write
    // a write lands on the edge where pready is seen high, byte or word strobe alike
    assign wr_commit = access && s_r.rsp.pready && !s_r.rsp.pslverr && apb_req.pwrite
                       && apb_req.pstrb[0] && (s_r.chip != e1rst_pkg::E1RST_CLEAR)
                       && (reg_idx < e1rst_pkg::NCTL_IDX);

    // addressed entry only
    // one decoder per entry so a write can never spill into a neighbour
    generate
        for (genvar gi = 0; gi < e1rst_pkg::NCTL; gi++)
        begin : g_hit
            assign wr_hit[gi] = wr_commit && (reg_idx == e1rst_pkg::IDX_W'(gi));
        end
    endgenerate

    // next-state logic for the whole block
    always_comb
    begin
        s_nxt = s_r;
        clearing = 1'h0;

        // pin synchroniser
        // pin is asynchronous, so it passes two flops before the counter sees it
        s_nxt.clr_meta  = chip_clear_input;
        s_nxt.clr_sync  = s_r.clr_meta;
        // live status
        // status pins resampled every cycle, no host action needed
        s_nxt.stat_meta = line_status;
        s_nxt.stat_sync = s_r.stat_meta;

        // low-time qualify
        // short glitches on the pin never reach the clear state
        case (s_r.chip)
            e1rst_pkg::E1RST_RUN:
            begin
                if (!s_r.clr_sync)
                begin
                    s_nxt.chip    = e1rst_pkg::E1RST_ARM;
                    s_nxt.clr_cnt = e1rst_pkg::CNT_ONE;
                end
            end
            e1rst_pkg::E1RST_ARM:
            begin
                if (s_r.clr_sync)
                begin
                    s_nxt.chip    = e1rst_pkg::E1RST_RUN;
                    s_nxt.clr_cnt = e1rst_pkg::CNT_ZERO;
                end
                else if (s_r.clr_cnt == e1rst_pkg::CLR_LAST)
                begin
                    s_nxt.chip = e1rst_pkg::E1RST_CLEAR;
                end
                else
                begin
                    s_nxt.clr_cnt = s_r.clr_cnt + e1rst_pkg::CNT_ONE;
                end
            end
            e1rst_pkg::E1RST_CLEAR:
            begin
                // clock assumed
                // leaving clear needs clock edges; a stopped clock freezes the chip here
                if (s_r.clr_sync)
                begin
                    s_nxt.chip    = e1rst_pkg::E1RST_RUN;
                    s_nxt.clr_cnt = e1rst_pkg::CNT_ZERO;
                end
            end
            default:
            begin
                s_nxt.chip    = e1rst_pkg::E1RST_RUN;
                s_nxt.clr_cnt = e1rst_pkg::CNT_ZERO;
            end
        endcase
        clearing = (s_nxt.chip == e1rst_pkg::E1RST_CLEAR);

        for (int i = 0; i < e1rst_pkg::NCTL; i++)
        begin
            if (wr_hit[i])
            begin
                s_nxt.ctl[i] = apb_req.pwdata[e1rst_pkg::REG_W-1:0];
            end
        end

        // table load
        // clear wins over a write in the same cycle
        if (clearing)
        begin
            s_nxt.ctl = e1rst_pkg::E1RST_DEF;
        end

        // apb answer
        // one wait state: data and pready registered together on the first access edge
        if (access && !s_r.rsp.pready)
        begin
            s_nxt.rsp.pready  = 1'h1;
            s_nxt.rsp.pslverr = 1'h0;
            s_nxt.rsp.prdata  = 32'h0000_0000;
            if ((apb_req.paddr[1:0] != 2'h0) || (s_r.chip == e1rst_pkg::E1RST_CLEAR))
            begin
                s_nxt.rsp.pslverr = 1'h1;
            end
            else if (reg_idx < e1rst_pkg::NCTL_IDX)
            begin
                s_nxt.rsp.prdata[e1rst_pkg::REG_W-1:0] = s_r.ctl[reg_idx];
            end
            // status read-only
            // writes to status words are answered but change nothing
            else if (reg_idx == e1rst_pkg::IDX_STATUS_PINS)
            begin
                s_nxt.rsp.prdata[e1rst_pkg::STAT_W-1:0] = s_r.stat_sync;
            end
            else if (reg_idx == e1rst_pkg::IDX_STATUS_CORE)
            begin
                s_nxt.rsp.prdata[e1rst_pkg::STAT_W-1:0] = {3'h0, s_r.cfg.irq_all_masked,
                                                           s_r.cfg.tx_tristate, s_r.cfg.doubleframe,
                                                           s_r.cfg.e1_mode, !s_r.cfg.out_oe_n};
            end
            else
            begin
                s_nxt.rsp.pslverr = 1'h1;
            end
        end
        else
        begin
            s_nxt.rsp.pready  = 1'h0;
            s_nxt.rsp.pslverr = 1'h0;
            s_nxt.rsp.prdata  = 32'h0000_0000;
        end

        // release outputs
        // output enables held off for the whole clear, active low
        s_nxt.cfg.out_oe_n = clearing;
        // standard bit
        // setting the line standard bit leaves E1, reflected straight away
        s_nxt.cfg.e1_mode = !s_nxt.ctl[e1rst_pkg::IDX_FRAMER_MODE_SECOND][e1rst_pkg::LINE_STANDARD_SELECT_BIT];
        s_nxt.cfg.doubleframe =
            (s_nxt.ctl[e1rst_pkg::IDX_FRAMER_MODE_THIRD][e1rst_pkg::FRAME_FMT_HI:e1rst_pkg::FRAME_FMT_LO] == 2'h0);
        s_nxt.cfg.tx_tristate = s_nxt.ctl[e1rst_pkg::IDX_TX_PULSE_SHAPE2][e1rst_pkg::TX_TRISTATE_BIT];
        s_nxt.cfg.irq_all_masked = 1'h1;
        for (int m = 0; m < e1rst_pkg::NIMR; m++)
        begin
            if (s_nxt.ctl[e1rst_pkg::IDX_INTERRUPT_MASK0 + e1rst_pkg::IDX_W'(m)] != e1rst_pkg::RV_MASK)
            begin
                s_nxt.cfg.irq_all_masked = 1'h0;
            end
        end
        // port rules are the host's; no checking here, a misuse is simply stored
    end

    // state register
    // sync reset loads constants only
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            s_r <= e1rst_pkg::E1RST_STATE_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state flops
    assign apb_rsp  = s_r.rsp;
    assign cfg      = s_r.cfg;
    assign ctl_regs = s_r.ctl;

    // checks, all on the core clock
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence seq_access_wait;
        access && !s_r.rsp.pready;
    endsequence

    sequence seq_answer;
        s_r.rsp.pready;
    endsequence

    AST_CLR_MIN: assert property ($rose(s_r.chip == e1rst_pkg::E1RST_CLEAR) |->
                                  $past(s_r.clr_cnt) == e1rst_pkg::CLR_LAST)
        else $error("clear entered without full low time");

    AST_HIZ: assert property ((s_r.chip == e1rst_pkg::E1RST_CLEAR) |-> s_r.cfg.out_oe_n)
        else $error("outputs enabled during clear");

    AST_DEFAULTS: assert property ((s_r.chip == e1rst_pkg::E1RST_CLEAR) |->
                                   s_r.ctl == e1rst_pkg::E1RST_DEF)
        else $error("registers not at defaults in clear");

    AST_E1_AFTER: assert property ($fell(s_r.chip == e1rst_pkg::E1RST_CLEAR) |->
                                   s_r.cfg.e1_mode && s_r.cfg.doubleframe)
        else $error("not E1 doubleframe after clear");

    AST_STAT_RO: assert property ((wr_commit == 1'h0) && (s_r.chip != e1rst_pkg::E1RST_CLEAR) &&
                                  (s_nxt.chip != e1rst_pkg::E1RST_CLEAR) |=> $stable(s_r.ctl))
        else $error("registers changed without a write");

    AST_RDY: assert property (seq_access_wait |=> seq_answer ##1 !s_r.rsp.pready)
        else $error("apb answer not after one wait state");

    AST_TRISTATE: assert property ($fell(s_r.chip == e1rst_pkg::E1RST_CLEAR) |->
                                   s_r.cfg.tx_tristate)
        else $error("transmitter not tristated after clear");

    AST_MASKED: assert property ($fell(s_r.chip == e1rst_pkg::E1RST_CLEAR) |->
                                 s_r.cfg.irq_all_masked)
        else $error("interrupt masks not all ones after clear");

    AST_WR_ONLY: assert property (wr_commit && (s_nxt.chip != e1rst_pkg::E1RST_CLEAR) |=>
                                  s_r.ctl[$past(reg_idx)] == $past(apb_req.pwdata[7:0]))
        else $error("write did not land on addressed register");

    AST_RD_DATA: assert property (seq_access_wait ##0 (reg_idx < e1rst_pkg::NCTL_IDX) &&
                                  (apb_req.paddr[1:0] == 2'h0) && (s_r.chip != e1rst_pkg::E1RST_CLEAR) |=>
                                  s_r.rsp.prdata[7:0] == $past(s_r.ctl[reg_idx]))
        else $error("read data mismatch");

    // refused access
    // bad alignment, beyond-map index or clear: error and zero data
    AST_REFUSE: assert property (seq_access_wait ##0 ((apb_req.paddr[1:0] != 2'h0) ||
                                 (reg_idx > e1rst_pkg::IDX_STATUS_CORE) ||
                                 (s_r.chip == e1rst_pkg::E1RST_CLEAR)) |=>
                                 s_r.rsp.pslverr && (s_r.rsp.prdata == 32'h0000_0000))
        else $error("refused access not answered with error");

    // outputs driven
    // outside clear the output stages are enabled again
    AST_OE_RUN: assert property ((s_r.chip != e1rst_pkg::E1RST_CLEAR) && $past(rst_n) |->
                                 !s_r.cfg.out_oe_n)
        else $error("outputs released outside clear");

    AST_STAT_LIVE: assert property (s_r.stat_sync == $past(s_r.stat_meta))
        else $error("status word not refreshed");

endmodule // e1rst_core

// >>> include/e1rst_pkg.sv
// package: constants, register defaults and carrier types of the reset/default-state block
package e1rst_pkg;

    // bus and register geometry
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 32;
    localparam int REG_W   = 8;
    localparam int IDX_W   = 6;
    localparam int STAT_W  = 8;
    localparam int NCTL    = 49;
    localparam logic [IDX_W-1:0] NCTL_IDX = 6'h31;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CLOCK_GEN_CONFIG   = 6'h00; // eight entries 0..7
    localparam logic [IDX_W-1:0] IDX_FRAMER_MODE_FIRST  = 6'h08;
    localparam logic [IDX_W-1:0] IDX_FRAMER_MODE_SECOND = 6'h09;
    localparam logic [IDX_W-1:0] IDX_FRAMER_MODE_THIRD  = 6'h0A;
    localparam logic [IDX_W-1:0] IDX_TX_PULSE_SHAPE2    = 6'h1C;
    localparam logic [IDX_W-1:0] IDX_INTERRUPT_MASK0    = 6'h1D; // six entries 29..34
    localparam logic [IDX_W-1:0] IDX_STATUS_PINS        = 6'h31;
    localparam logic [IDX_W-1:0] IDX_STATUS_CORE        = 6'h32;
    localparam int NIMR = 6;

    // field positions
    localparam int LINE_STANDARD_SELECT_BIT = 7; // framer_mode_second, 1 = T1/J1
    localparam int FRAME_FMT_HI             = 7; // framer_mode_third, 00 = doubleframe
    localparam int FRAME_FMT_LO             = 6;
    localparam int TX_TRISTATE_BIT          = 6; // tx_pulse_shape2

    // reset values
    localparam logic [REG_W-1:0] RV_ZERO = 8'h00;
    localparam logic [REG_W-1:0] RV_SLOT = 8'h9C;
    localparam logic [REG_W-1:0] RV_XPM0 = 8'h7B;
    localparam logic [REG_W-1:0] RV_XPM1 = 8'h03;
    localparam logic [REG_W-1:0] RV_XPM2 = 8'h40;
    localparam logic [REG_W-1:0] RV_MASK = 8'hFF;

    typedef logic [NCTL-1:0][REG_W-1:0] e1rst_regs_t;

    // defaults, highest index first
    localparam e1rst_regs_t E1RST_DEF = '{
        RV_ZERO,                                               // 48 port_cfg_five
        RV_ZERO, RV_ZERO,                                      // 47 sig ctrl mode, 46 clock_mux_cfg_b
        RV_ZERO,                                               // 45 clock_mux_cfg_a
        RV_ZERO, RV_ZERO,                                      // 44..43 slot_select_extra_b/a
        RV_ZERO, RV_ZERO, RV_ZERO, RV_ZERO,                    // 42..39 tx_slot_select
        RV_ZERO, RV_ZERO, RV_ZERO, RV_ZERO,                    // 38..35 rx_slot_select
        RV_MASK, RV_MASK, RV_MASK, RV_MASK, RV_MASK, RV_MASK,  // 34..29 interrupt_mask_bank
        RV_XPM2, RV_XPM1, RV_XPM0,                             // 28..26 tx_pulse_shape
        RV_ZERO, RV_ZERO,                                      // 25 los_recover_count, 24 los_detect_count
        RV_ZERO, RV_ZERO,                                      // 23..22 line_iface_cfg_b/a
        RV_SLOT, RV_ZERO,                                      // 21 rx_slot_offset, 20 rx_clock_offset
        RV_SLOT, RV_ZERO,                                      // 19 tx_slot_offset, 18 tx_clock_offset
        RV_ZERO, RV_ZERO, RV_ZERO, RV_ZERO,                    // 17 transparent_word_mode .. 14 chan loop
        RV_ZERO, RV_ZERO, RV_ZERO,                             // 13..11 system_iface_cfg_c/b/a
        RV_ZERO, RV_ZERO, RV_ZERO,                             // 10..8 framer_mode_third/second/first
        RV_ZERO, RV_ZERO, RV_ZERO, RV_ZERO,                    // 7..0 clock_gen_config
        RV_ZERO, RV_ZERO, RV_ZERO, RV_ZERO
    };

    // chip-clear timing: minimum low time of chip_clear_input
    localparam int CLK_MHZ    = 100;
    localparam int CLR_MIN_US = 10;
    localparam int CLR_CYC    = CLR_MIN_US * CLK_MHZ;
    localparam int CNT_W      = 11;
    localparam logic [CNT_W-1:0] CLR_LAST = CNT_W'(CLR_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ONE  = 11'h001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;

    typedef enum logic [1:0] {E1RST_RUN, E1RST_ARM, E1RST_CLEAR} e1rst_chip_e;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
        logic [3:0]        pstrb;
    } e1rst_apb_req_s;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic              pready;
        logic              pslverr;
    } e1rst_apb_rsp_s;

    typedef struct packed {
        logic out_oe_n;       // high = all output stages released
        logic e1_mode;
        logic doubleframe;
        logic tx_tristate;
        logic irq_all_masked;
    } e1rst_cfg_s;

    typedef struct packed {
        logic              clr_meta;
        logic              clr_sync;
        logic [CNT_W-1:0]  clr_cnt;
        e1rst_chip_e       chip;
        e1rst_regs_t       ctl;
        logic [STAT_W-1:0] stat_meta;
        logic [STAT_W-1:0] stat_sync;
        e1rst_apb_rsp_s    rsp;
        e1rst_cfg_s        cfg;
    } e1rst_state_s;

    localparam e1rst_state_s E1RST_STATE_RST = '{
        clr_meta:  1'h1,
        clr_sync:  1'h1,
        clr_cnt:   CNT_ZERO,
        chip:      E1RST_RUN,
        ctl:       E1RST_DEF,
        stat_meta: 8'h00,
        stat_sync: 8'h00,
        rsp:       '{prdata: 32'h0000_0000, pready: 1'h0, pslverr: 1'h0},
        cfg:       '{out_oe_n: 1'h1, e1_mode: 1'h1, doubleframe: 1'h1, tx_tristate: 1'h1, irq_all_masked: 1'h1}
    };

endpackage

// >>> dv/e1rst_host_model.sv
// host model: apb master and chip-clear pin driver standing in for the microprocessor
module e1rst_host_model (
    input  wire logic                      core_clk,
    input  wire e1rst_pkg::e1rst_apb_rsp_s apb_rsp,
    output e1rst_pkg::e1rst_apb_req_s      apb_req,
    output logic                           chip_clear_input
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus and released clear pin from time zero
    initial
    begin
        apb_req = '0;
        chip_clear_input = 1'b1;
    end

    // one transfer, request held until pready is sampled high
    // port and mode bits only changed when a test asks
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [31:0] rd, output logic err);
        @(posedge core_clk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: s};
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        // no cycle limit of its own: only the bench watchdog ends a stuck wait
        do
            @(posedge core_clk);
        while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        // released lines show the inverse so stale values never pass
        apb_req <= '{psel: 1'b0, penable: 1'b0, pwrite: ~w, paddr: ~a, pwdata: ~d, pstrb: ~s};
    endtask

    // clear pin low for cyc cycles, clock left running
    task automatic clear_pulse(input int cyc);
        @(posedge core_clk);
        chip_clear_input <= 1'b0;
        repeat (cyc) @(posedge core_clk);
        chip_clear_input <= 1'b1;
    endtask
endmodule // e1rst_host_model

// >>> dv/tb_top.sv
// testbench top: reset defaults, register access, refusals, status and chip clear
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int W = 392;
    logic                      core_clk;
    logic                      rst_n;
    logic                      chip_clear_input;
    logic [7:0]                line_status;
    e1rst_pkg::e1rst_apb_req_s apb_req;
    e1rst_pkg::e1rst_apb_rsp_s apb_rsp;
    e1rst_pkg::e1rst_cfg_s     cfg;
    e1rst_pkg::e1rst_regs_t    ctl_regs;
    e1rst_pkg::e1rst_regs_t    shadow;
    logic [31:0]               rdat;
    logic                      rerr;
    int                        fail_count;
    int                        checks_done;

    e1rst_core e1rst_core_i (.core_clk(core_clk), .rst_n(rst_n), .chip_clear_input(chip_clear_input),
        .line_status(line_status), .apb_req(apb_req), .apb_rsp(apb_rsp), .cfg(cfg), .ctl_regs(ctl_regs));
    e1rst_host_model e1rst_host_model_i (.core_clk(core_clk), .apb_rsp(apb_rsp), .apb_req(apb_req),
        .chip_clear_input(chip_clear_input));

    // clock keeps running, also through clear
    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;

    // expected reset value per control index
    function automatic logic [7:0] def_val(input int i);
        if (i >= 26 && i <= 28)
            return (i == 26) ? 8'h7B : (i == 27) ? 8'h03 : 8'h40;
        if (i >= 29 && i <= 34)
            return 8'hFF;
        if (i == 19 || i == 21)
            return 8'h9C;
        return 8'h00;
    endfunction

    // inverse of default flips every bit; port_cfg_five stays zero for the host
    function automatic logic [7:0] pat(input int i);
        return (i == 48) ? 8'h00 : ~def_val(i);
    endfunction

    function automatic e1rst_pkg::e1rst_regs_t defaults();
        e1rst_pkg::e1rst_regs_t r;
        for (int i = 0; i < e1rst_pkg::NCTL; i++)
            r[i] = def_val(i);
        return r;
    endfunction

    task automatic chk(input logic [W-1:0] seen, input logic [W-1:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        e1rst_host_model_i.xfer(w, a, d, s, rdat, rerr);
    endtask

    // every control register read over the bus against the shadow copy
    task automatic read_all();
        for (int i = 0; i < e1rst_pkg::NCTL; i++)
        begin
            acc(1'b0, 8'(4 * i), 32'h0000_0000, 4'h0);
            chk(W'({rerr, rdat}), W'({9'h000, 16'h0000, shadow[i]}));
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // watchdog: the tests need about 2700 cycles
    initial
    begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        tally_and_finish();
    end

    initial
    begin
        fail_count = 0;
        checks_done = 0;
        rst_n = 1'b0;
        line_status = 8'h00;
        repeat (5) @(posedge core_clk);
        chk(W'(cfg.out_oe_n), W'(1'b1));
        @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        shadow = defaults();
        chk(W'(cfg), W'(5'h0F));
        chk(W'(ctl_regs), W'(shadow));
        read_all();
        $display("test reset_defaults done");
        // byte and word writes alternate; upper lanes carry junk
        for (int i = 0; i < e1rst_pkg::NCTL; i++)
        begin
            acc(1'b1, 8'(4 * i), {24'hA5C3E1, pat(i)}, (i % 2) ? 4'hF : 4'h1);
            shadow[i] = pat(i);
            @(posedge core_clk);
            chk(W'(ctl_regs), W'(shadow));
        end
        chk(W'(cfg), W'(5'h00));
        read_all();
        $display("test write_readback done");
        // unaligned and beyond-map accesses are refused, no write lands
        acc(1'b1, 8'h01, 32'h0000_0011, 4'hF);
        chk(W'({rerr, rdat}), W'(33'h1_0000_0000));
        acc(1'b0, 8'hCC, 32'h0000_0000, 4'h0);
        chk(W'({rerr, rdat}), W'(33'h1_0000_0000));
        acc(1'b1, 8'hCC, 32'h0000_0022, 4'hF);
        acc(1'b1, 8'h20, 32'h0000_0077, 4'h2);
        acc(1'b1, 8'hC4, 32'h0000_00FF, 4'hF);
        // a wrong write would only show after its commit edge
        @(posedge core_clk);
        chk(W'({rerr, ctl_regs}), W'({1'b0, shadow}));
        // status follows the pins with no host action
        line_status <= 8'h5A;
        repeat (4) @(posedge core_clk);
        acc(1'b0, 8'hC4, 32'h0000_0000, 4'h0);
        chk(W'({rerr, rdat}), W'(33'h0_0000_005A));
        line_status <= 8'hA5;
        repeat (4) @(posedge core_clk);
        acc(1'b0, 8'hC4, 32'h0000_0000, 4'h0);
        chk(W'({rerr, rdat}), W'(33'h0_0000_00A5));
        acc(1'b0, 8'hC8, 32'h0000_0000, 4'h0);
        chk(W'({rerr, rdat}), W'(33'h0_0000_0001));
        $display("test refusals_status done");
        // a short clear pulse must leave everything alone
        e1rst_host_model_i.clear_pulse(990);
        repeat (6) @(posedge core_clk);
        chk(W'({cfg.out_oe_n, ctl_regs}), W'({1'b0, shadow}));
        fork
            e1rst_host_model_i.clear_pulse(1020);
            begin
                repeat (1012) @(posedge core_clk);
                chk(W'(cfg.out_oe_n), W'(1'b1));
                acc(1'b1, 8'h20, 32'h0000_00FF, 4'hF);
                chk(W'({rerr, rdat}), W'(33'h1_0000_0000));
            end
        join
        shadow = defaults();
        repeat (8) @(posedge core_clk);
        chk(W'(ctl_regs), W'(shadow));
        chk(W'(cfg), W'(5'h0F));
        acc(1'b0, 8'hC8, 32'h0000_0000, 4'h0);
        chk(W'({rerr, rdat}), W'(33'h0_0000_001F));
        $display("test chip_clear done");
        // a second reset in mid-run restores the defaults
        acc(1'b1, 8'h74, 32'h0000_0000, 4'h1);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk(W'(ctl_regs), W'(shadow));
        $display("test second_reset done");
        tally_and_finish();
    end
endmodule // tb_top
